//--- rtl/oapld_pkg.sv
// constants, types and register map of the or / pointer-load execute unit
// assumes one 200 MHz clock and an avalon-mm slave port with 32-bit data
package oapld_pkg;

	// ----------------------------------------------------------------
	// clock
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000; // 200 MHz core clock

	// ----------------------------------------------------------------
	// register map: word index, byte address is four times the index
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int ADDR_LSB = 2;
	localparam logic [3:0] IDX_INSTR = 4'h0;    // instruction word, write starts a cycle
	localparam logic [3:0] IDX_ACC = 4'h1;      // accumulator
	localparam logic [3:0] IDX_BANK = 4'h2;     // bank pointer
	localparam logic [3:0] IDX_STATUS = 4'h3;   // zero, sign, second word pending
	localparam logic [3:0] IDX_PTR0 = 4'h4;     // indirect pointer 0, read only
	localparam logic [3:0] IDX_PTR1 = 4'h5;     // indirect pointer 1, read only
	localparam logic [3:0] IDX_PTR2 = 4'h6;     // indirect pointer 2, read only
	localparam logic [3:0] IDX_MEM_ADDR = 4'h7; // data memory window address
	localparam logic [3:0] IDX_MEM_DATA = 4'h8; // data memory window data

	// status register bits
	localparam int STAT_ZERO = 0;
	localparam int STAT_SIGN = 1;
	localparam int STAT_PEND = 2;

	// ----------------------------------------------------------------
	// instruction fields
	// ----------------------------------------------------------------
	localparam int OP_MSB = 15;
	localparam int ORL_LSB = 8;
	localparam int ORF_LSB = 10;
	localparam int PTR_FIRST_LSB = 6;
	localparam int LIT_MSB = 7;
	localparam int DIR_BIT = 9;
	localparam int BANKSEL_BIT = 8;
	localparam int SEL_MSB = 5;
	localparam int SEL_LSB = 4;
	localparam int HI_LIT_MSB = 3;
	localparam int SIGN_BIT = 7;
	localparam logic [7:0] ORL_OPCODE = 8'h09;         // 0000 1001
	localparam logic [5:0] ORF_OPCODE = 6'h04;         // 0001 00
	localparam logic [9:0] PTR_FIRST_OPCODE = 10'h3B8; // 1110 1110 00
	localparam logic [7:0] PTR_SECOND_OPCODE = 8'hF0;  // 1111 0000
	localparam logic [1:0] PTR_SEL_MAX = 2'h2;

	// access bank: low half from bank 0, high half from the top bank
	localparam logic [3:0] ACCESS_BANK_LOW = 4'h0;
	localparam logic [3:0] ACCESS_BANK_HIGH = 4'hF;

	// data memory
	localparam int MEM_AW = 12;
	localparam int MEM_DEPTH = 4096;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {PH_IDLE, PH_Q1, PH_Q2, PH_Q3, PH_Q4} oapld_phase_t;
	typedef enum logic [2:0] {OP_NONE, OP_ORL, OP_ORF, OP_PTR1, OP_PTR2} oapld_op_t;
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DONE} oapld_rd_t;

	typedef struct packed {
		oapld_phase_t phase;
		oapld_op_t op;
		oapld_rd_t rd;
		logic [15:0] instr;
		logic [7:0] acc;
		logic [3:0] bank;
		logic zero;
		logic sign;
		logic pend;
		logic [1:0] sel;
		logic [2:0][3:0] ptr_high;
		logic [2:0][7:0] ptr_low;
		logic [7:0] result;
		logic [11:0] addr;
		logic [11:0] mem_addr;
		logic [31:0] readdata;
	} oapld_state_t;

	typedef struct packed {
		logic [11:0] addr;
		logic we;
		logic [7:0] wdata;
	} oapld_mem_req_t;

	localparam oapld_state_t STATE_RESET = '0;

endpackage

//--- rtl/oapld_alu.sv
// or unit: result and its sign and zero flags
// assumes operands stable through the process quarter
`timescale 1ns/1ps
module oapld_alu
	import oapld_pkg::*;
(
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	output logic [7:0] result,
	output logic sign,
	output logic zero
);

	// ----------------------------------------------------------------
	// combinational or and flags
	// ----------------------------------------------------------------
	always_comb
	begin
		result = a | b;
		sign = result[SIGN_BIT];
		zero = (result == 8'h00);
	end

endmodule

//--- rtl/oapld_mem.sv
// data memory, single port, registered read data
// assumes one request per clock, write and read share the address
`timescale 1ns/1ps
module oapld_mem
	import oapld_pkg::*;
(
	input wire logic clk,
	input wire oapld_mem_req_t req,
	output logic [7:0] rdata
);

	logic [7:0] mem [MEM_DEPTH];

	// ----------------------------------------------------------------
	// write on request, read data one clock after the address
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (req.we)
		begin
			mem[req.addr] <= req.wdata;
		end
		rdata <= mem[req.addr];
	end

endmodule

//--- rtl/oapld_core.sv
// execute unit for or-literal, or-with-register and pointer-load, avalon-mm slave
// assumes the master holds a request until waitrequest is seen low
`timescale 1ns/1ps

// Summary of operation
// - Opcode upper byte 0000 1001 ors the literal into the accumulator, touching only sign and zero.
// - Pattern 0001 00da ors accumulator with a register, result to the accumulator when d is 0, else the register.
// - With the bank bit 0 the access bank is used, with it 1 the bank pointer forms the address.
// - The register or is one word and one cycle: read in the second quarter, process, write in the fourth.
// - Pointer load is decoded from first word 1110 1110 00ff kkkk and second word 1111 0000 kkkk kkkk.
// - Pointer load puts a 12-bit literal into the selected indirect pointer and changes no flags.
// - Pointer load takes two cycles: high bits in the first fourth quarter, low byte in the second.
module oapld_core
	import oapld_pkg::*;
(
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);

	oapld_state_t st;
	oapld_state_t next_st;
	oapld_mem_req_t mem_req;
	logic [7:0] mem_rdata;
	logic [7:0] alu_b;
	logic [7:0] alu_result;
	logic [3:0] reg_idx;
	logic idle;
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// byte-lane merge of a bus write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// data address from bank bit, register field and bank pointer
	function automatic logic [11:0] data_addr(input logic use_bank, input logic [7:0] f, input logic [3:0] bank);
		logic [3:0] hi;
		hi = f[SIGN_BIT] ? ACCESS_BANK_HIGH : ACCESS_BANK_LOW;
		if (use_bank)
		begin
			hi = bank;
		end
		return {hi, f};
	endfunction

	assign reg_idx = AVS_ADDRESS[ADDR_W-1:ADDR_LSB];
	assign idle = (st.phase == PH_IDLE);

	// ----------------------------------------------------------------
	// or unit and data memory
	// ----------------------------------------------------------------

	// literal for the literal form, memory data for the register form
	assign alu_b = (st.op == OP_ORL) ? st.instr[LIT_MSB:0] : mem_rdata;

	oapld_alu i_oapld_alu (
		.a(st.acc),
		.b(alu_b),
		.result(alu_result),
		.sign(),
		.zero()
	);

	// memory port: bus window when idle, instruction operand otherwise
	always_comb
	begin
		mem_req.addr = idle ? st.mem_addr : st.addr;
		mem_req.wdata = idle ? AVS_WRITEDATA[7:0] : st.result;
		mem_req.we = (st.phase == PH_Q4 && st.op == OP_ORF && st.instr[DIR_BIT])
			|| (idle && AVS_WRITE && reg_idx == IDX_MEM_DATA && AVS_BYTEENABLE[0]);
	end

	oapld_mem i_oapld_mem (
		.clk(CLK),
		.req(mem_req),
		.rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// bus handshake
	// ----------------------------------------------------------------

	// writes stall while busy, reads answer on the third cycle
	assign AVS_WAITREQUEST = (AVS_WRITE && !idle) || (AVS_READ && st.rd != RD_DONE);
	assign AVS_READDATA = st.readdata;

	// read multiplexer, unmapped words read zero
	always_comb
	begin
		case (reg_idx)
			IDX_INSTR: rd_mux = 32'(st.instr);
			IDX_ACC: rd_mux = 32'(st.acc);
			IDX_BANK: rd_mux = 32'(st.bank);
			IDX_STATUS: rd_mux = 32'({st.pend, st.sign, st.zero});
			IDX_PTR0: rd_mux = 32'({st.ptr_high[0], st.ptr_low[0]});
			IDX_PTR1: rd_mux = 32'({st.ptr_high[1], st.ptr_low[1]});
			IDX_PTR2: rd_mux = 32'({st.ptr_high[2], st.ptr_low[2]});
			IDX_MEM_ADDR: rd_mux = 32'(st.mem_addr);
			IDX_MEM_DATA: rd_mux = 32'(mem_rdata);
			default: rd_mux = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		unique case (st.phase)
			PH_IDLE:
			begin
				// register writes
				if (AVS_WRITE)
				begin
					case (reg_idx)
						IDX_INSTR:
						begin
							next_st.instr = 16'(merge(32'(st.instr), AVS_WRITEDATA, AVS_BYTEENABLE));
							next_st.phase = PH_Q1;
						end
						IDX_ACC: next_st.acc = 8'(merge(32'(st.acc), AVS_WRITEDATA, AVS_BYTEENABLE));
						IDX_BANK: next_st.bank = 4'(merge(32'(st.bank), AVS_WRITEDATA, AVS_BYTEENABLE));
						IDX_MEM_ADDR: next_st.mem_addr = 12'(merge(32'(st.mem_addr), AVS_WRITEDATA, AVS_BYTEENABLE));
						default: next_st.mem_addr = st.mem_addr;
					endcase
				end
				// read pipeline: wait, capture, answer
				if (AVS_READ)
				begin
					unique case (st.rd)
						RD_IDLE: next_st.rd = RD_WAIT;
						RD_WAIT:
						begin
							next_st.rd = RD_DONE;
							next_st.readdata = rd_mux;
						end
						RD_DONE: next_st.rd = RD_IDLE;
					endcase
				end
				else
				begin
					next_st.rd = RD_IDLE;
				end
			end
			PH_Q1:
			begin
				// decode quarter
				next_st.phase = PH_Q2;
				next_st.op = OP_NONE;
				next_st.pend = 1'b0;
				// second word continues a pending load
				if (st.pend && st.instr[OP_MSB:ORL_LSB] == PTR_SECOND_OPCODE)
				begin
					next_st.op = OP_PTR2;
				end
				else if (st.instr[OP_MSB:ORL_LSB] == ORL_OPCODE)
				begin
					next_st.op = OP_ORL;
				end
				else if (st.instr[OP_MSB:ORF_LSB] == ORF_OPCODE)
				begin
					next_st.op = OP_ORF;
				end
				else if (st.instr[OP_MSB:PTR_FIRST_LSB] == PTR_FIRST_OPCODE)
				begin
					next_st.op = OP_PTR1;
					next_st.sel = st.instr[SEL_MSB:SEL_LSB];
				end
				next_st.addr = data_addr(st.instr[BANKSEL_BIT], st.instr[LIT_MSB:0], st.bank);
			end
			PH_Q2:
			begin
				// register read, address already on the memory
				next_st.phase = PH_Q3;
			end
			PH_Q3:
			begin
				next_st.phase = PH_Q4;
				next_st.result = alu_result;
			end
			PH_Q4:
			begin
				next_st.phase = PH_IDLE;
				unique case (st.op)
					OP_ORL, OP_ORF:
					begin
						if (st.op == OP_ORL || !st.instr[DIR_BIT])
						begin
							next_st.acc = st.result;
						end
						next_st.sign = st.result[SIGN_BIT];
						next_st.zero = (st.result == 8'h00);
					end
					OP_PTR1:
					begin
						if (st.sel <= PTR_SEL_MAX)
						begin
							next_st.ptr_high[st.sel] = st.instr[HI_LIT_MSB:0];
						end
						next_st.pend = 1'b1;
					end
					OP_PTR2:
					begin
						if (st.sel <= PTR_SEL_MAX)
						begin
							next_st.ptr_low[st.sel] = st.instr[LIT_MSB:0];
						end
					end
					OP_NONE: next_st.op = OP_NONE;
				endcase
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			st <= STATE_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	orl_result_a: assert property (st.phase == PH_Q4 && st.op == OP_ORL |=>
		st.acc == ($past(st.instr[LIT_MSB:0]) | $past(st.acc)))
		else $error("literal or gave wrong accumulator");

	orf_to_acc_a: assert property (st.phase == PH_Q4 && st.op == OP_ORF && !st.instr[DIR_BIT] |->
		!mem_req.we ##1 st.acc == $past(st.result))
		else $error("register or to accumulator wrong");

	orf_to_reg_a: assert property (st.phase == PH_Q4 && st.op == OP_ORF && st.instr[DIR_BIT] |->
		mem_req.we && mem_req.wdata == st.result && mem_req.addr == st.addr ##1 $stable(st.acc))
		else $error("register or to register wrong");

	access_bank_a: assert property (st.phase == PH_Q2 && st.op == OP_ORF && !st.instr[BANKSEL_BIT] |->
		mem_req.addr[MEM_AW-1:ORL_LSB] == (st.instr[SIGN_BIT] ? ACCESS_BANK_HIGH : ACCESS_BANK_LOW))
		else $error("access bank not used");

	bank_select_a: assert property (st.phase == PH_Q2 && st.op == OP_ORF && st.instr[BANKSEL_BIT] |->
		mem_req.addr == {st.bank, st.instr[LIT_MSB:0]})
		else $error("bank pointer not used");

	orf_quarters_a: assert property (st.phase == PH_Q2 && st.op == OP_ORF |->
		##1 st.phase == PH_Q3 ##1 st.phase == PH_Q4 ##1 st.phase == PH_IDLE)
		else $error("register or quarter sequence wrong");

	ptr_decode_a: assert property (st.phase == PH_Q1 && st.pend && st.instr[OP_MSB:ORL_LSB] == PTR_SECOND_OPCODE |=>
		st.op == OP_PTR2)
		else $error("pointer second word not decoded");

	ptr_flags_a: assert property (st.phase == PH_Q4 && (st.op == OP_PTR1 || st.op == OP_PTR2) |=>
		$stable(st.zero) && $stable(st.sign))
		else $error("pointer load changed flags");

	// high part written in first cycle
	ptr_high_a: assert property (st.phase == PH_Q4 && st.op == OP_PTR1 && st.sel <= PTR_SEL_MAX |=>
		st.ptr_high[$past(st.sel)] == $past(st.instr[HI_LIT_MSB:0]) && st.pend)
		else $error("pointer high part wrong");

	// low part written in second cycle
	ptr_low_a: assert property (st.phase == PH_Q4 && st.op == OP_PTR2 && st.sel <= PTR_SEL_MAX |=>
		st.ptr_low[$past(st.sel)] == $past(st.instr[LIT_MSB:0]) && !st.pend)
		else $error("pointer low part wrong");

	or_flags_a: assert property (st.phase == PH_Q4 && (st.op == OP_ORL || st.op == OP_ORF) |=>
		st.zero == ($past(st.result) == 8'h00) && st.sign == $past(st.result[SIGN_BIT]))
		else $error("or flags wrong");

	// main scenarios
	orl_done_c: cover property (st.phase == PH_Q4 && st.op == OP_ORL);
	orf_reg_c: cover property (st.phase == PH_Q4 && st.op == OP_ORF && st.instr[DIR_BIT]);
	ptr_full_c: cover property (st.phase == PH_Q4 && st.op == OP_PTR2);
	bus_read_c: cover property (AVS_READ && !AVS_WAITREQUEST);

endmodule

//--- testbench/oapld_core_tb.sv
// self-checking bench for the or / pointer-load execute unit
// assumes the avalon-mm slave port is driven here directly, no partner model
`timescale 1ns/1ps

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module oapld_core_tb
	import oapld_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic CLK;
	logic SYS_RST;
	logic [ADDR_W-1:0] AVS_ADDRESS;
	logic AVS_READ;
	logic AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	int errors;
	int n_compared;

	oapld_core i_oapld_core (
		.CLK(CLK),
		.SYS_RST(SYS_RST),
		.AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST)
	);

	// 200 MHz clock
	initial
	begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	// counts, verdict and end of run
	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// one avalon transfer, held until waitrequest low at a rising edge
	task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [31:0] d,
		output logic [31:0] q, output int waits);
		logic done;
		AVS_ADDRESS <= {idx, 2'b00};
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr_en;
		AVS_READ <= ~wr_en;
		waits = 0;
		done = 1'b0;
		q = '0;
		// sample at the rising edge, values standing before it
		while (!done)
		begin
			@(posedge CLK);
			if (AVS_WAITREQUEST === 1'b0)
			begin
				done = 1'b1;
				q = AVS_READDATA;
			end
			else
			begin
				waits++;
				if (waits > 40)
				begin
					errors++;
					$display("bus wait ran out at t=%0t", $time);
					test_done();
				end
			end
		end
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] q;
		int w;
		bus(1'b1, idx, d, q, w);
	endtask

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		int w;
		bus(1'b0, idx, 32'h0, q, w);
		`CHK(q, exp)
	endtask

	// instruction write, then a write to an unused word that must stall
	task automatic exec(input logic [15:0] instr);
		logic [31:0] q;
		int w;
		wr(IDX_INSTR, {16'h0, instr});
		bus(1'b1, 4'hF, 32'h0, q, w);
		`CHK(w, 4)
	endtask

	task automatic mem_set(input logic [11:0] a, input logic [7:0] d);
		wr(IDX_MEM_ADDR, {20'h0, a});
		wr(IDX_MEM_DATA, {24'h0, d});
	endtask

	task automatic mem_chk(input logic [11:0] a, input logic [7:0] exp);
		wr(IDX_MEM_ADDR, {20'h0, a});
		rd_chk(IDX_MEM_DATA, {24'h0, exp});
	endtask

	task automatic idle();
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge CLK);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values, unused word, read-only pointer
	task automatic t_reset();
		rd_chk(IDX_ACC, 32'h0);
		rd_chk(IDX_STATUS, 32'h0);
		AVS_BYTEENABLE <= 4'hE;
		wr(IDX_ACC, 32'h55);
		AVS_BYTEENABLE <= 4'hF;
		rd_chk(IDX_ACC, 32'h0);
		wr(IDX_PTR0, 32'hFFF);
		for (int f = 0; f < 3; f++)
			rd_chk(IDX_PTR0 + f[3:0], 32'h0);
		rd_chk(4'hF, 32'h0);
		idle();
		$display("test reset done");
	endtask

	task automatic t_orl();
		wr(IDX_ACC, 32'h9A);
		exec(16'h0935);
		rd_chk(IDX_ACC, 32'hBF);
		rd_chk(IDX_STATUS, 32'h2);
		exec(16'h0880);
		rd_chk(IDX_ACC, 32'hBF);
		rd_chk(IDX_STATUS, 32'h2);
		wr(IDX_ACC, 32'h0);
		exec(16'h0900);
		rd_chk(IDX_ACC, 32'h0);
		rd_chk(IDX_STATUS, 32'h1);
		idle();
		$display("test or literal done");
	endtask

	task automatic t_orf();
		wr(IDX_BANK, 32'h3);
		mem_set(12'h010, 8'h13);
		mem_set(12'h310, 8'h44);
		mem_set(12'hF90, 8'h40);
		mem_set(12'h390, 8'h00);
		mem_set(12'h3FF, 8'h00);
		wr(IDX_ACC, 32'h91);
		exec(16'h1010);
		rd_chk(IDX_ACC, 32'h93);
		rd_chk(IDX_STATUS, 32'h2);
		mem_chk(12'h010, 8'h13);
		wr(IDX_ACC, 32'h01);
		exec(16'h1290);
		mem_chk(12'hF90, 8'h41);
		mem_chk(12'h390, 8'h00);
		rd_chk(IDX_ACC, 32'h01);
		rd_chk(IDX_STATUS, 32'h0);
		exec(16'h1310);
		mem_chk(12'h310, 8'h45);
		mem_chk(12'h010, 8'h13);
		wr(IDX_ACC, 32'h0);
		exec(16'h11FF);
		rd_chk(IDX_ACC, 32'h0);
		rd_chk(IDX_STATUS, 32'h1);
		idle();
		$display("test or register done");
	endtask

	task automatic t_ptr();
		logic [11:0] k [3];
		k[0] = 12'h3AB;
		k[1] = 12'hFFF;
		k[2] = 12'h5C1;
		for (int f = 0; f < 3; f++)
		begin
			exec({8'hEE, 2'b00, f[1:0], k[f][11:8]});
			rd_chk(IDX_PTR0 + f[3:0], {20'h0, k[f][11:8], 8'h00});
			rd_chk(IDX_STATUS, 32'h5);
			exec({8'hF0, k[f][7:0]});
			rd_chk(IDX_PTR0 + f[3:0], {20'h0, k[f]});
			rd_chk(IDX_STATUS, 32'h1);
		end
		exec(16'hEE3F);
		exec(16'hF000);
		exec(16'hF012);
		for (int f = 0; f < 3; f++)
			rd_chk(IDX_PTR0 + f[3:0], {20'h0, k[f]});
		rd_chk(IDX_STATUS, 32'h1);
		idle();
		$display("test pointer load done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	// reset for five cycles, then the scenarios
	initial
	begin
		errors = 0;
		n_compared = 0;
		SYS_RST = 1'b1;
		AVS_ADDRESS = '0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hF;
		repeat (5) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(posedge CLK);
		t_reset();
		t_orl();
		t_orf();
		t_ptr();
		test_done();
	end

endmodule
